// >>> pkg/sprc_pkg.sv
// Constants and carrier types for the self polling run control block.
// Assumes one 125 MHz clock with synchronous active-high reset.
package sprc_pkg;
	localparam int          SPRC_PRESCALE   = 64;
	localparam logic [3:0]  SPRC_PORT_LO    = 4'hE;
	localparam logic [7:0]  SPRC_SEL_LO     = 8'h0E;
	localparam logic [7:0]  SPRC_SEL_HI     = 8'hE0;
	localparam int          SPRC_TO_W       = 16;
	localparam logic [15:0] SPRC_TO_RST     = 16'h0000;

	typedef enum logic [1:0] {
		SPRC_MODE_CONST,
		SPRC_MODE_FALLBACK,
		SPRC_MODE_MIXED,
		SPRC_MODE_PERMANENT
	} sprc_mode_e;

	typedef enum logic [1:0] {
		SPRC_AFT_NEXT,
		SPRC_AFT_CFGA,
		SPRC_AFT_RELOAD
	} sprc_after_e;

	typedef enum logic [2:0] {
		SPRC_IDLE,
		SPRC_POLL,
		SPRC_OFF,
		SPRC_RUN
	} sprc_state_e;

	typedef struct packed {
		logic        master_select;
		sprc_mode_e  polling_mode;
		logic        two_configs;
		sprc_after_e after_end;
		logic        return_on_message_end;
		logic        fifo_clear_on_frame;
		logic        external_processing_select;
		logic        parallel_wakeup_enable;
		logic        shared_pattern_enable;
		logic        id_scan_enable;
		logic [2:0]  irq_mask;
		logic [7:0]  polling_reference_value;
		logic [15:0] sync_loss_timeout;
		logic [15:0] frame_start_timeout;
		logic [15:0] message_end_timeout;
		logic [7:0]  port_config_low;
		logic [7:0]  port_config_high;
	} sprc_cfg_s;

	typedef struct packed {
		logic       wakeup;
		logic       symbol_sync;
		logic       frame_start;
		logic       message_id;
		logic       end_of_message;
		logic       fifo_locked;
		logic       on_time_done;
		logic [7:0] channel;
	} sprc_ev_s;
endpackage

// >>> hdl/sprc_core.sv
// Run-after-wake-up control, parallel wake-up search and polling timer front end.
// Assumes events from the demodulator other than the symbol_sync level are one-cycle pulses synchronous to clk_i.
`timescale 1ns/100ps
module sprc_core
	import sprc_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire sprc_cfg_s         cfg_i,
	input  wire sprc_ev_s          ev_i,
	input  wire logic              sleep_cmd_i,
	input  wire logic              external_timeout_cmd_i,
	input  wire logic              external_message_end_cmd_i,
	input  wire logic [DATA_W-1:0] rx_data_i,
	input  wire logic              rx_valid_i,
	output logic                   rx_ready_o,
	output logic [DATA_W-1:0]      fifo_data_o,
	output logic                   fifo_valid_o,
	input  wire logic              fifo_ready_i,
	output logic                   fifo_clear_o,
	output logic                   run_state_o,
	output logic                   polling_o,
	output logic                   config_b_o,
	output logic                   modulation_switch_o,
	output logic                   frame_search_o,
	output logic                   id_scan_o,
	output logic                   parallel_search_o,
	output logic                   framer_reset_o,
	output logic [2:0]             irq_o,
	output logic [8:0]             received_channel_status_o,
	output logic                   polling_timer_init_o,
	output logic                   ref_tick_o,
	output logic [3:0]             port_sync_o
);

	typedef struct packed {
		sprc_state_e             st;
		logic                    cfg_b;
		logic                    in_frame;
		logic                    first_done;
		logic                    pws_active;
		logic [SPRC_TO_W-1:0]    to_sync;
		logic [SPRC_TO_W-1:0]    to_fs;
		logic [SPRC_TO_W-1:0]    to_end;
		logic [5:0]              pre;
		logic [7:0]              ref_cnt;
		logic                    tick;
		logic [2:0]              irq;
		logic [8:0]              chan;
		logic                    fclr;
		logic                    ptinit;
		logic                    frst;
		logic [1:0]              cnt;
		logic [1:0][DATA_W-1:0]  buf_d;
		logic                    wp;
		logic                    rp;
	} sprc_st_s;

	sprc_st_s s_r;
	sprc_st_s s_nxt;

	function automatic logic port_pick(input logic [7:0] cfg, input logic hi);
		port_pick = hi ? (cfg == SPRC_SEL_HI) : (cfg == SPRC_SEL_LO);
	endfunction

	logic leave;
	logic go_a;
	logic ext_ok;
	logic ext_to;
	logic ext_end;
	logic msg_end;
	logic last_cfg;
	logic push;
	logic pop;

	always_comb begin
		s_nxt = s_r;
		s_nxt.irq = 3'h0;
		s_nxt.fclr = 1'b0;
		s_nxt.ptinit = 1'b0;
		s_nxt.frst = 1'b0;
		s_nxt.tick = 1'b0;
		ext_ok = cfg_i.external_processing_select;
		ext_to = ext_ok && external_timeout_cmd_i;
		ext_end = ext_ok && external_message_end_cmd_i;
		msg_end = ev_i.end_of_message || ext_end;
		last_cfg = !cfg_i.two_configs || s_r.cfg_b;
		leave = 1'b0;
		go_a = 1'b0;

		// Reference timer: fixed prescale then programmable scale
		if (s_r.pre == 6'(SPRC_PRESCALE - 1)) begin
			s_nxt.pre = 6'h00;
			if (s_r.ref_cnt >= cfg_i.polling_reference_value) begin
				s_nxt.ref_cnt = 8'h00;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.ref_cnt = s_r.ref_cnt + 8'h01;
			end
		end else begin
			s_nxt.pre = s_r.pre + 6'h01;
		end

		case (s_r.st)
			SPRC_IDLE: begin
				if (cfg_i.master_select) begin
					s_nxt.st = SPRC_POLL;
					s_nxt.cfg_b = 1'b0;
					s_nxt.ptinit = 1'b1;
				end
			end
			SPRC_POLL: begin
				if (ev_i.wakeup) begin
					s_nxt.st = SPRC_RUN;
					s_nxt.in_frame = 1'b0;
					s_nxt.first_done = 1'b0;
					s_nxt.pws_active = 1'b0;
					s_nxt.to_sync = cfg_i.sync_loss_timeout;
					s_nxt.to_fs = cfg_i.frame_start_timeout;
					s_nxt.to_end = cfg_i.message_end_timeout;
					s_nxt.fclr = !cfg_i.fifo_clear_on_frame;
					s_nxt.frst = !cfg_i.shared_pattern_enable;
				end else if (ev_i.on_time_done) begin
					if (last_cfg) begin
						s_nxt.st = SPRC_OFF;
					end else begin
						s_nxt.cfg_b = 1'b1;
					end
				end
			end
			SPRC_OFF: begin
				if (ev_i.on_time_done) begin
					s_nxt.st = SPRC_POLL;
					s_nxt.cfg_b = 1'b0;
					s_nxt.ptinit = 1'b1;
				end
			end
			SPRC_RUN: begin
				// Timeout counters count reference ticks
				if (s_r.tick) begin
					if (!ev_i.symbol_sync && s_r.to_sync != SPRC_TO_RST) begin
						s_nxt.to_sync = s_r.to_sync - 16'h0001;
					end
					if (!s_r.in_frame && s_r.to_fs != SPRC_TO_RST) begin
						s_nxt.to_fs = s_r.to_fs - 16'h0001;
					end
					if (s_r.in_frame && s_r.to_end != SPRC_TO_RST) begin
						s_nxt.to_end = s_r.to_end - 16'h0001;
					end
				end
				if (ev_i.symbol_sync) begin
					s_nxt.to_sync = cfg_i.sync_loss_timeout;
				end
				if (ev_i.frame_start && !s_r.in_frame) begin
					s_nxt.in_frame = 1'b1;
					s_nxt.pws_active = 1'b0;
					s_nxt.irq[0] = 1'b1;
					s_nxt.fclr = cfg_i.fifo_clear_on_frame && !ev_i.fifo_locked;
				end
				if (ev_i.message_id && cfg_i.id_scan_enable) begin
					s_nxt.irq[1] = 1'b1;
				end
				// Parallel wake-up search between frames
				if (cfg_i.parallel_wakeup_enable && s_r.first_done && !s_r.in_frame
					&& !ev_i.frame_start) begin
					if (ev_i.symbol_sync && !s_r.pws_active) begin
						s_nxt.pws_active = 1'b1;
					end else if (!ev_i.symbol_sync || ev_i.wakeup) begin
						s_nxt.pws_active = 1'b0;
					end
				end
				if (s_r.pws_active && ev_i.wakeup) begin
					s_nxt.fclr = !cfg_i.fifo_clear_on_frame;
					s_nxt.frst = !cfg_i.shared_pattern_enable;
				end
				if (msg_end) begin
					s_nxt.irq[2] = ev_i.end_of_message;
					s_nxt.in_frame = 1'b0;
					s_nxt.first_done = 1'b1;
					s_nxt.chan = {s_r.cfg_b, ev_i.channel};
					if (cfg_i.return_on_message_end || ext_end) begin
						leave = cfg_i.after_end != SPRC_AFT_RELOAD || !ext_end;
					end
					if (!leave) begin
						s_nxt.to_sync = cfg_i.sync_loss_timeout;
						s_nxt.to_fs = cfg_i.frame_start_timeout;
						s_nxt.to_end = cfg_i.message_end_timeout;
					end
				end
				if (ext_to || (s_r.to_sync == SPRC_TO_RST && !ev_i.symbol_sync)
					|| (!s_r.in_frame && s_r.to_fs == SPRC_TO_RST)
					|| (s_r.in_frame && s_r.to_end == SPRC_TO_RST)) begin
					leave = 1'b1;
				end
				if (leave) begin
					go_a = cfg_i.after_end == SPRC_AFT_CFGA;
					if (go_a || cfg_i.polling_mode == SPRC_MODE_CONST) begin
						s_nxt.ptinit = 1'b1;
					end
					if (go_a) begin
						s_nxt.st = SPRC_POLL;
						s_nxt.cfg_b = 1'b0;
					end else if (last_cfg) begin
						s_nxt.st = SPRC_OFF;
					end else begin
						s_nxt.st = SPRC_POLL;
						s_nxt.cfg_b = 1'b1;
					end
				end
			end
			default: s_nxt.st = SPRC_IDLE;
		endcase

		if (!cfg_i.master_select || sleep_cmd_i) begin
			s_nxt.st = SPRC_IDLE;
			s_nxt.pws_active = 1'b0;
		end
		s_nxt.irq = s_nxt.irq & ~cfg_i.irq_mask;

		// Two-entry data buffer; cleared with the FIFO
		push = rx_valid_i && s_r.cnt != 2'd2 && s_r.st == SPRC_RUN && s_r.in_frame;
		pop = fifo_ready_i && s_r.cnt != 2'd0;
		if (push) begin
			s_nxt.buf_d[s_r.wp] = rx_data_i;
			s_nxt.wp = !s_r.wp;
		end
		if (pop) begin
			s_nxt.rp = !s_r.rp;
		end
		s_nxt.cnt = s_r.cnt + 2'(push) - 2'(pop);
		if (s_r.fclr) begin
			s_nxt.cnt = 2'd0;
			s_nxt.wp = 1'b0;
			s_nxt.rp = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rx_ready_o = s_r.cnt != 2'd2 && s_r.st == SPRC_RUN && s_r.in_frame;
	assign fifo_valid_o = s_r.cnt != 2'd0;
	assign fifo_data_o = s_r.buf_d[s_r.rp];
	assign fifo_clear_o = s_r.fclr;
	assign run_state_o = s_r.st == SPRC_RUN;
	assign polling_o = s_r.st == SPRC_POLL;
	assign config_b_o = s_r.cfg_b;
	assign modulation_switch_o = s_r.st == SPRC_RUN;
	assign frame_search_o = s_r.st == SPRC_RUN && !s_r.in_frame;
	assign id_scan_o = s_r.st == SPRC_RUN && s_r.in_frame && cfg_i.id_scan_enable;
	assign parallel_search_o = s_r.pws_active;
	assign framer_reset_o = s_r.frst;
	assign irq_o = s_r.irq;
	assign received_channel_status_o = s_r.chan;
	assign polling_timer_init_o = s_r.ptinit;
	assign ref_tick_o = s_r.tick;

	// Symbol sync routing to the four output ports
	for (genvar p = 0; p < 4; p++) begin : g_port
		assign port_sync_o[p] = ev_i.symbol_sync
			&& port_pick(p < 2 ? cfg_i.port_config_low : cfg_i.port_config_high, (p % 2) == 1);
	end

endmodule

// >>> sim/sprc_sink.sv
// Host-side reader of the receive buffer, able to stall on request.
// Assumes the valid/ready handshake of sprc_core on clk_i.
`timescale 1ns/100ps
module sprc_sink (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       stall_i,
	input  wire logic [7:0] data_i,
	input  wire logic       valid_i,
	output logic            ready_o,
	output int              count_o
);
	logic [7:0] got [8];

	always_ff @(posedge clk_i) begin
		ready_o <= !rst_i && !stall_i;
		if (rst_i) begin
			count_o <= 0;
		end else if (valid_i && ready_o) begin
			got[count_o[2:0]] <= data_i;
			count_o           <= count_o + 1;
		end
	end
endmodule

// >>> sim/sprc_monitor.sv
// Port assertions for the run control block.
// Bound into every sprc_core instance; sees only its ports.
`timescale 1ns/100ps
module sprc_monitor
	import sprc_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire sprc_cfg_s  cfg_i,
	input wire sprc_ev_s   ev_i,
	input wire logic       sleep_cmd_i,
	input wire logic       run_state_o,
	input wire logic       polling_o,
	input wire logic       config_b_o,
	input wire logic       parallel_search_o,
	input wire logic       ref_tick_o,
	input wire logic [2:0] irq_o,
	input wire logic [3:0] port_sync_o,
	input wire logic [8:0] received_channel_status_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_end;
		run_state_o && ev_i.end_of_message;
	endsequence
	sequence s_fs;
		run_state_o && ev_i.frame_start && !cfg_i.irq_mask[0];
	endsequence
	property p_enter; polling_o && ev_i.wakeup |=> run_state_o; endproperty
	a_enter: assert property (p_enter) else $error("no run entry");
	property p_fs_irq; s_fs |=> irq_o[0]; endproperty
	a_fs_irq: assert property (p_fs_irq) else $error("no frame irq");
	property p_end_irq; s_end ##0 !cfg_i.irq_mask[2] |=> irq_o[2]; endproperty
	a_end_irq: assert property (p_end_irq) else $error("no end irq");
	property p_status;
		s_end |=> received_channel_status_o == {$past(config_b_o), $past(ev_i.channel)};
	endproperty
	a_status: assert property (p_status) else $error("bad status");
	property p_ret; s_end ##0 cfg_i.return_on_message_end |=> !run_state_o; endproperty
	a_ret: assert property (p_ret) else $error("no return");
	property p_sleep; run_state_o && sleep_cmd_i |=> !run_state_o; endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep exit");
	property p_psearch; parallel_search_o && !ev_i.symbol_sync |=> !parallel_search_o; endproperty
	a_psearch: assert property (p_psearch) else $error("search kept");
	property p_tick; ref_tick_o |=> (!ref_tick_o) [*8]; endproperty
	a_tick: assert property (p_tick) else $error("tick too fast");
	property p_port;
		cfg_i.port_config_low == SPRC_SEL_LO |-> port_sync_o[0] == ev_i.symbol_sync;
	endproperty
	a_port: assert property (p_port) else $error("bad port");
endmodule

bind sprc_core sprc_monitor i_sprc_monitor (.*);

// >>> sim/tb_top.sv
// Self-checking bench for the run control block.
// Assumes sprc_pkg, sprc_core, sprc_sink and sprc_monitor are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module tb_top
	import sprc_pkg::*;
;
	localparam sprc_ev_s EV_WU = 15'h4000, EV_FS = 15'h1000;
	localparam sprc_ev_s EV_ID = 15'h0800, EV_END = 15'h0400;
	logic       clk_i = 1'b0, rst_i = 1'b1, stall = 1'b1, rx_valid_i = 1'b0;
	logic       sleep_cmd_i = 1'b0, external_timeout_cmd_i = 1'b0;
	logic       external_message_end_cmd_i = 1'b0, fifo_ready_i, acc;
	logic       rx_ready_o, fifo_valid_o, fifo_clear_o, run_state_o, polling_o, config_b_o;
	logic       modulation_switch_o, frame_search_o, id_scan_o, parallel_search_o;
	logic       framer_reset_o, polling_timer_init_o, ref_tick_o;
	logic [7:0] rx_data_i = 8'h00, fifo_data_o;
	logic [2:0] irq_o;
	logic [3:0] port_sync_o;
	logic [8:0] received_channel_status_o;
	sprc_cfg_s  cfg_i;
	sprc_ev_s   ev_i;
	int         fails = 0, comparisons = 0, got_n, n;

	sprc_core i_sprc_core (.*);
	sprc_sink i_sprc_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .data_i(fifo_data_o),
		.valid_i(fifo_valid_o), .ready_o(fifo_ready_i), .count_o(got_n));

	always #4 clk_i = ~clk_i;

	task automatic end_sim();
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wait_st(input logic poll, input logic v);
		for (n = 0; n < 3000 && (poll ? polling_o : run_state_o) !== v; n++) @(negedge clk_i);
		if (n == 3000) begin
			fails++;
			end_sim();
		end
	endtask

	task automatic pulse(input sprc_ev_s p);
		ev_i = ev_i | p;
		@(negedge clk_i);
		ev_i = ev_i & ~p;
	endtask

	task automatic t_enter();
		ev_i.symbol_sync = 1'b1;
		#1;
		`CHK(port_sync_o, 4'b1001)
		@(negedge clk_i);
		cfg_i.master_select = 1'b1;
		wait_st(1'b1, 1'b1);
		`CHK(polling_o, 1'b1)
		`CHK(polling_timer_init_o, 1'b1)
		for (n = 0; n < 300 && ref_tick_o !== 1'b1; n++) @(negedge clk_i);
		@(negedge clk_i);
		for (n = 1; n < 300 && ref_tick_o !== 1'b1; n++) @(negedge clk_i);
		`CHK(n, 128)
		pulse(EV_WU);
		`CHK(run_state_o, 1'b1)
		`CHK(fifo_clear_o, 1'b1)
		`CHK(parallel_search_o, 1'b0)
		`CHK(modulation_switch_o, 1'b1)
		`CHK(frame_search_o, 1'b1)
		`CHK(framer_reset_o, 1'b1)
	endtask

	task automatic t_frame();
		int m = 0;
		pulse(EV_FS);
		`CHK(irq_o, 3'b001)
		`CHK(id_scan_o, 1'b1)
		pulse(EV_ID);
		`CHK(irq_o, 3'b010)
		rx_valid_i = 1'b1;
		for (int k = 0; k < 6; k++) begin
			rx_data_i = 8'hA0 + 8'(m);
			acc = rx_ready_o;
			@(negedge clk_i);
			m += int'(acc);
		end
		rx_valid_i = 1'b0;
		`CHK(m, 2)
		stall = 1'b0;
		repeat (6) @(negedge clk_i);
		`CHK(got_n, 2)
		`CHK(fifo_valid_o, 1'b0)
		`CHK(i_sprc_sink.got[1], 8'hA1)
		ev_i.channel = 8'h5A;
		pulse(EV_END);
		`CHK(irq_o, 3'b100)
		`CHK(received_channel_status_o, 9'h05A)
		`CHK(run_state_o, 1'b1)
		ev_i.symbol_sync = 1'b0;
		@(negedge clk_i);
		ev_i.symbol_sync = 1'b1;
		repeat (2) @(negedge clk_i);
		`CHK(parallel_search_o, 1'b1)
		ev_i.symbol_sync = 1'b0;
		@(negedge clk_i);
		ev_i.symbol_sync = 1'b1;
		`CHK(parallel_search_o, 1'b0)
		cfg_i.irq_mask = 3'b001;
		pulse(EV_FS);
		`CHK(irq_o, 3'b000)
		cfg_i.irq_mask = 3'b000;
		pulse(EV_END);
	endtask

	task automatic t_exit();
		external_timeout_cmd_i = 1'b1;
		@(negedge clk_i);
		external_timeout_cmd_i = 1'b0;
		`CHK(run_state_o, 1'b1)
		cfg_i.external_processing_select = 1'b1;
		external_message_end_cmd_i = 1'b1;
		@(negedge clk_i);
		external_message_end_cmd_i = 1'b0;
		`CHK(run_state_o, 1'b1)
		cfg_i.after_end = SPRC_AFT_CFGA;
		external_timeout_cmd_i = 1'b1;
		@(negedge clk_i);
		external_timeout_cmd_i = 1'b0;
		`CHK(polling_o, 1'b1)
		cfg_i.frame_start_timeout = 16'h0002;
		pulse(EV_WU);
		wait_st(1'b0, 1'b0);
		`CHK(n > 127, 1'b1)
		`CHK(polling_o, 1'b1)
		cfg_i.frame_start_timeout = 16'hFFFF;
		cfg_i.return_on_message_end = 1'b1;
		pulse(EV_WU);
		pulse(EV_FS);
		pulse(EV_END);
		`CHK(run_state_o, 1'b0)
		pulse(EV_WU);
		sleep_cmd_i = 1'b1;
		@(negedge clk_i);
		sleep_cmd_i = 1'b0;
		`CHK(run_state_o, 1'b0)
	endtask

	initial begin
		cfg_i = '0;
		cfg_i.after_end = SPRC_AFT_RELOAD;
		cfg_i.parallel_wakeup_enable = 1'b1;
		cfg_i.id_scan_enable = 1'b1;
		cfg_i.polling_reference_value = 8'h01;
		cfg_i.sync_loss_timeout = 16'hFFFF;
		cfg_i.frame_start_timeout = 16'hFFFF;
		cfg_i.message_end_timeout = 16'hFFFF;
		cfg_i.port_config_low = SPRC_SEL_LO;
		cfg_i.port_config_high = SPRC_SEL_HI;
		ev_i = '0;
		repeat (5) @(negedge clk_i);
		rst_i = 1'b0;
		t_enter();
		t_frame();
		t_exit();
		end_sim();
	end
endmodule
